//--- hw/wt_pkg.sv
// What this block does
// - Count clock is main clock over 128 when bit 7 is 0, else subclock.
// - Interval event every 2^4..2^9 count clocks for codes 0 to 5 in bits 6:4.
// - Counter-run 1 lets the 5-bit counter count; 0 stops and clears it.
// - Enable 0 stops the unit and clears prescaler and 5-bit counter.
// - Reset clears the whole mode register to zero.
// - Mode register takes whole-byte writes and single-bit writes.
// - Watch event every 0.5 s at 32.768 kHz: prescaler feeds counter overflow.
// - Watch and interval run together and share one interrupt request.
// - Enable and run both 1 start the watch; writing them 0 clears and stops.
// - Clearing only run clears and stops the watch count while the prescaler keeps going.
// - Counter starts one prescaler cycle late, so the first watch event is off.
package wt_pkg;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int unsigned CLOCK_HZ           = 20_000_000;
  localparam int unsigned CLOCK_PERIOD_NS    = 50;
  localparam int unsigned MAIN_DIVIDE        = 128;
  localparam int unsigned SUB_CLOCK_HZ       = 32_768;
  localparam int unsigned WATCH_PERIOD_MS    = 500;
  localparam int unsigned WATCH_PERIOD_TICKS =
    SUB_CLOCK_HZ * WATCH_PERIOD_MS / 1000;
  localparam int unsigned PRESCALER_WIDTH    = 9;
  localparam int unsigned COUNTER_WIDTH      = 5;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam int unsigned ADDR_WIDTH           = 16;
  localparam int unsigned DATA_WIDTH           = 8;
  localparam logic [15:0] WATCH_MODE_OFFSET    = 16'hff4a;
  localparam logic [15:0] EVENT_STATUS_OFFSET  = 16'hff4b;
  localparam logic [15:0] EVENT_MASK_OFFSET    = 16'hff4c;
  localparam logic [7:0]  WATCH_MODE_RESET     = 8'h00;
  localparam logic [7:0]  WATCH_MODE_WRITABLE  = 8'hf3;
  localparam logic [1:0]  EVENT_MASK_RESET     = 2'h0;
  localparam int unsigned EVENT_COUNT          = 2;
  localparam int unsigned EVT_WATCH_BIT        = 0;
  localparam int unsigned EVT_INTERVAL_BIT     = 1;

  // Mode register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       clock_source_select;
    logic [2:0] interval_select;
    logic [1:0] reserved_zero;
    logic       counter_run;
    logic       unit_enable;
  } watch_mode_t;

  typedef enum logic [2:0] {
    CNT_IDLE = 3'b001,
    CNT_ARM  = 3'b010,
    CNT_RUN  = 3'b100
  } count_state_t;

  // Low prescaler bits that must all be ones for an interval event
  function automatic logic [8:0] tap_mask(input logic [2:0] code);
    case (code)
      3'h0:    tap_mask = 9'h00f;
      3'h1:    tap_mask = 9'h01f;
      3'h2:    tap_mask = 9'h03f;
      3'h3:    tap_mask = 9'h07f;
      3'h4:    tap_mask = 9'h0ff;
      default: tap_mask = 9'h1ff;
    endcase
  endfunction : tap_mask

endpackage : wt_pkg

//--- hw/count_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module count_tick_gen
  import wt_pkg::*;
#(
  parameter int unsigned DIVIDE = MAIN_DIVIDE
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // Control
  input  wire logic enable_in,
  input  wire logic use_sub_clock_in,
  // Subsystem clock pin
  input  wire logic sub_clock_in,
  // One-cycle count clock tick
  output logic      tick_out
);

  localparam int unsigned DW = $clog2(DIVIDE);

  // ******************************************************
  // Parameter check
  // ******************************************************
  if (DIVIDE < 2) begin : g_bad_divide
    $error("count_tick_gen: DIVIDE must be at least 2");
  end

  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          sync3;
    logic [DW-1:0] div;
    logic          tick;
  } tick_state_t;

  tick_state_t st_reg;
  tick_state_t st_next;

  // Subclock is a pin: two flops before the edge detector looks at it
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = sub_clock_in;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    st_next.tick  = 1'b0;
    if (!enable_in || use_sub_clock_in) begin
      st_next.div = '0;
    end else if (st_reg.div == DW'(DIVIDE - 1)) begin
      st_next.div  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + DW'(1);
    end
    if (enable_in && use_sub_clock_in) begin
      st_next.tick = st_reg.sync2 && !st_reg.sync3;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_out = st_reg.tick;

endmodule : count_tick_gen
`default_nettype wire

//--- hw/event_status.sv
`timescale 1ns/1ps
`default_nettype none
module event_status
  import wt_pkg::*;
#(
  parameter int unsigned EVENTS = EVENT_COUNT
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  // Events and software access
  input  wire logic [EVENTS-1:0] event_in,
  input  wire logic              read_clear_in,
  input  wire logic              mask_write_in,
  input  wire logic [EVENTS-1:0] mask_data_in,
  // State
  output logic      [EVENTS-1:0] status_out,
  output logic      [EVENTS-1:0] mask_out,
  output logic                   irq_out
);

  if (EVENTS < 1 || EVENTS > DATA_WIDTH) begin : g_bad_events
    $error("event_status: EVENTS must be 1 to DATA_WIDTH");
  end

  typedef struct packed {
    logic [EVENTS-1:0] status;
    logic [EVENTS-1:0] mask;
  } status_state_t;

  status_state_t st_reg;
  status_state_t st_next;

  // A new event beats the read clear of the same cycle
  always_comb begin
    st_next        = st_reg;
    st_next.status = (read_clear_in ? '0 : st_reg.status) | event_in;
    if (mask_write_in) begin
      st_next.mask = mask_data_in;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_out = st_reg.status;
  assign mask_out   = st_reg.mask;
  assign irq_out    = |(st_reg.status & st_reg.mask);

endmodule : event_status
`default_nettype wire

//--- hw/watch_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module watch_interval_timer
  import wt_pkg::*;
#(
  parameter int unsigned DIVIDE = MAIN_DIVIDE
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_b_in,
  // Register port
  input  wire logic [ADDR_WIDTH-1:0] addr_in,
  input  wire logic [DATA_WIDTH-1:0] wr_data_in,
  input  wire logic [DATA_WIDTH-1:0] wr_bits_in,
  input  wire logic                  wr_strobe_in,
  input  wire logic                  rd_strobe_in,
  output logic      [DATA_WIDTH-1:0] rd_data_out,
  // Subsystem clock pin
  input  wire logic                  sub_clock_in,
  // Interrupts
  output logic                       tick_interrupt_request_out,
  output logic                       irq_out
);

  // ******************************************************
  // Parameter check
  // ******************************************************
  if (WATCH_PERIOD_TICKS != (1 << (PRESCALER_WIDTH + COUNTER_WIDTH)))
  begin : g_bad_period
    $error("watch_interval_timer: watch period does not fit chain");
  end
  if (DIVIDE < 2) begin : g_bad_divide
    $error("watch_interval_timer: DIVIDE must be at least 2");
  end

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    watch_mode_t                mode;
    logic [PRESCALER_WIDTH-1:0] prescaler;
    logic [COUNTER_WIDTH-1:0]   counter;
    count_state_t               cnt_state;
    logic [DATA_WIDTH-1:0]      rd_data;
    logic                       req;
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;

  logic                   tick;
  logic                   running;
  logic                   pre_ovf;
  logic                   watch_evt;
  logic                   interval_evt;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] status;
  logic [EVENT_COUNT-1:0] mask;
  logic [EVENT_COUNT-1:0] mask_data;
  logic                   mode_write;
  logic                   mask_write;
  logic                   status_read;
  logic [DATA_WIDTH-1:0]  mode_merged;

  // ******************************************************
  // Count clock
  // ******************************************************
  count_tick_gen #(
    .DIVIDE           (DIVIDE)
  ) u_tick (
    .clock_in         (clock_in),
    .rst_b_in         (rst_b_in),
    .enable_in        (st_reg.mode.unit_enable),
    .use_sub_clock_in (st_reg.mode.clock_source_select),
    .sub_clock_in     (sub_clock_in),
    .tick_out         (tick)
  );

  // ******************************************************
  // Event decode
  // ******************************************************
  // Both functions tap the one prescaler, so they run side by side
  assign running      = st_reg.mode.unit_enable && st_reg.mode.counter_run;
  assign pre_ovf      = tick && st_reg.mode.unit_enable &&
                        (st_reg.prescaler == '1);
  assign interval_evt = tick && st_reg.mode.unit_enable &&
                        ((st_reg.prescaler &
                          tap_mask(st_reg.mode.interval_select)) ==
                         tap_mask(st_reg.mode.interval_select));
  assign watch_evt    = pre_ovf && running &&
                        (st_reg.cnt_state == CNT_RUN) &&
                        (st_reg.counter == '1);

  assign events[EVT_WATCH_BIT]    = watch_evt;
  assign events[EVT_INTERVAL_BIT] = interval_evt;

  // Register decode; single-bit writes leave other bits alone
  assign mode_write  = wr_strobe_in && (addr_in == WATCH_MODE_OFFSET);
  assign mask_write  = wr_strobe_in && (addr_in == EVENT_MASK_OFFSET);
  assign status_read = rd_strobe_in && (addr_in == EVENT_STATUS_OFFSET);
  assign mode_merged = ((st_reg.mode & ~wr_bits_in) |
                        (wr_data_in & wr_bits_in)) & WATCH_MODE_WRITABLE;
  assign mask_data   = (mask & ~wr_bits_in[EVENT_COUNT-1:0]) |
                       (wr_data_in[EVENT_COUNT-1:0] &
                        wr_bits_in[EVENT_COUNT-1:0]);

  // ******************************************************
  // Next state
  // ******************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.req     = watch_evt || interval_evt;
    st_next.rd_data = '0;

    // Reserved bits are forced low whatever software writes
    if (mode_write) begin
      st_next.mode = watch_mode_t'(mode_merged);
    end

    // Prescaler runs whenever the unit is enabled
    if (!st_reg.mode.unit_enable) begin
      st_next.prescaler = '0;
    end else if (tick) begin
      st_next.prescaler = st_reg.prescaler + 9'h001;
    end

    // Counter skips the first prescaler overflow after a start
    case (st_reg.cnt_state)
      CNT_IDLE: begin
        st_next.counter = '0;
        if (running) begin
          st_next.cnt_state = CNT_ARM;
        end
      end
      CNT_ARM: begin
        st_next.counter = '0;
        if (!running) begin
          st_next.cnt_state = CNT_IDLE;
        end else if (pre_ovf) begin
          st_next.cnt_state = CNT_RUN;
        end
      end
      CNT_RUN: begin
        if (!running) begin
          st_next.counter   = '0;
          st_next.cnt_state = CNT_IDLE;
        end else if (pre_ovf) begin
          st_next.counter = st_reg.counter + 5'h01;
        end
      end
      default: begin
        st_next.counter   = '0;
        st_next.cnt_state = CNT_IDLE;
      end
    endcase

    // Read data stands only in the cycle after the strobe
    if (rd_strobe_in) begin
      case (addr_in)
        WATCH_MODE_OFFSET:   st_next.rd_data = st_reg.mode;
        EVENT_STATUS_OFFSET: st_next.rd_data = DATA_WIDTH'(status);
        EVENT_MASK_OFFSET:   st_next.rd_data = DATA_WIDTH'(mask);
        default:             st_next.rd_data = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      st_reg           <= '0;
      st_reg.mode      <= watch_mode_t'(WATCH_MODE_RESET);
      st_reg.cnt_state <= CNT_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ******************************************************
  // Sticky status and mask
  // ******************************************************
  event_status #(
    .EVENTS        (EVENT_COUNT)
  ) u_status (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .event_in      (events),
    .read_clear_in (status_read),
    .mask_write_in (mask_write),
    .mask_data_in  (mask_data),
    .status_out    (status),
    .mask_out      (mask),
    .irq_out       (irq_out)
  );

  assign rd_data_out                = st_reg.rd_data;
  assign tick_interrupt_request_out = st_reg.req;

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  a_reset_mode_zero: assert property (
    $rose(rst_b_in) |-> (st_reg.mode == watch_mode_t'(WATCH_MODE_RESET)))
    else $error("mode register not zero after reset");

  a_reserved_bits_low: assert property (
    st_reg.mode.reserved_zero == 2'h0)
    else $error("reserved mode bits set");

  a_disable_clears_all: assert property (
    !st_reg.mode.unit_enable |=> (st_reg.prescaler == '0) &&
                                 (st_reg.counter == '0))
    else $error("prescaler or counter not cleared while disabled");

  a_run_low_clears: assert property (
    !st_reg.mode.counter_run |=> (st_reg.counter == '0))
    else $error("counter not cleared while run is low");

  a_prescaler_keeps: assert property (
    (st_reg.mode.unit_enable && !st_next.mode.counter_run &&
     st_next.mode.unit_enable && !tick)
    |=> (st_reg.prescaler == $past(st_reg.prescaler)))
    else $error("prescaler disturbed by counter stop");

  a_bit_write_keeps: assert property (
    (mode_write && !wr_bits_in[0])
    |=> (st_reg.mode.unit_enable == $past(st_reg.mode.unit_enable)))
    else $error("untouched enable bit changed by a bit write");

  a_arm_skips_one: assert property (
    (st_reg.cnt_state == CNT_ARM && pre_ovf && running)
    |=> (st_reg.counter == '0) && (st_reg.cnt_state == CNT_RUN))
    else $error("counter did not skip first prescaler overflow");

  a_watch_on_wrap: assert property (
    watch_evt |-> (st_reg.counter == 5'h1f) &&
                  (st_reg.prescaler == 9'h1ff))
    else $error("watch event without full chain wrap");

  a_interval_tap: assert property (
    interval_evt |-> ((st_reg.prescaler[3:0] == 4'hf) &&
                      (st_reg.mode.interval_select < 3'h5 ||
                       st_reg.prescaler == 9'h1ff)))
    else $error("interval event off its tap");

  a_request_pulse: assert property (
    tick_interrupt_request_out |=> !tick_interrupt_request_out)
    else $error("interrupt request longer than one cycle");

  a_request_status: assert property (
    tick_interrupt_request_out |-> (status != '0))
    else $error("request without a status bit");

  // A start from idle always passes through the skip state
  a_start_arms: assert property (
    (running && st_reg.cnt_state == CNT_IDLE)
    |=> (st_reg.cnt_state == CNT_ARM))
    else $error("start did not arm the counter");

  // Dropping run mid-count must wipe the count, not freeze it
  a_stop_clears_count: assert property (
    (st_reg.cnt_state == CNT_RUN && !running)
    |=> (st_reg.counter == '0) && (st_reg.cnt_state == CNT_IDLE))
    else $error("watch count survived a stop");

  // Prohibited codes must fall on the longest tap, never in between
  a_long_code_tap: assert property (
    (interval_evt && st_reg.mode.interval_select > 3'h5)
    |-> (st_reg.prescaler == 9'h1ff))
    else $error("prohibited code tapped short");

  // Each count tick moves the prescaler by exactly one
  a_prescaler_step: assert property (
    (st_reg.mode.unit_enable && tick)
    |=> (st_reg.prescaler == $past(st_reg.prescaler) + 9'h001))
    else $error("prescaler missed a count tick");

  // A disabled unit sees no count ticks one cycle later
  a_no_tick_disabled: assert property (
    tick |-> $past(st_reg.mode.unit_enable))
    else $error("count tick while the unit was disabled");

  // Every event, watch or interval, reaches the request line
  a_event_request: assert property (
    (watch_evt || interval_evt) |=> tick_interrupt_request_out)
    else $error("event lost before the request line");

  // No request pulse appears without an event behind it
  a_request_from_event: assert property (
    tick_interrupt_request_out |-> $past(watch_evt || interval_evt))
    else $error("request pulse without an event");

  // Scenarios the bench is expected to reach
  c_watch_event: cover property (watch_evt);
  c_interval_event: cover property (interval_evt && running);
  c_status_read: cover property (status_read && (status != '0));
  c_prohibited_code: cover property (interval_evt &&
                                     st_reg.mode.interval_select == 3'h7);
  c_sub_clock_tick: cover property (tick && st_reg.mode.clock_source_select);

endmodule : watch_interval_timer
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import wt_pkg::*;
;
  // ******************************************************
  // Bench setup
  // ******************************************************
  localparam int DIV = 2;         // Short main-clock divider keeps runs brief
  localparam int CEILING = 90000; // Whole run is about 80k cycles
  localparam int WATCH_CLKS = WATCH_PERIOD_TICKS * DIV;

  logic                  clock_in;
  logic                  rst_b_in;
  logic [ADDR_WIDTH-1:0] addr_in;
  logic [DATA_WIDTH-1:0] wr_data_in;
  logic [DATA_WIDTH-1:0] wr_bits_in;
  logic                  wr_strobe_in;
  logic                  rd_strobe_in;
  logic [DATA_WIDTH-1:0] rd_data_out;
  logic                  sub_clock_in;
  logic                  tick_interrupt_request_out;
  logic                  irq_out;
  logic                  sub_on;
  logic                  rd_seen = 1'b0;
  logic [7:0]            exp_q[$];
  string                 name_q[$];
  int                    err_count = 0;
  int                    n_compared = 0;
  int                    cyc = 0;

  watch_interval_timer #(
    .DIVIDE(DIV)
  ) uut (
    .clock_in                  (clock_in),
    .rst_b_in                  (rst_b_in),
    .addr_in                   (addr_in),
    .wr_data_in                (wr_data_in),
    .wr_bits_in                (wr_bits_in),
    .wr_strobe_in              (wr_strobe_in),
    .rd_strobe_in              (rd_strobe_in),
    .rd_data_out               (rd_data_out),
    .sub_clock_in              (sub_clock_in),
    .tick_interrupt_request_out(tick_interrupt_request_out),
    .irq_out                   (irq_out)
  );

  // ******************************************************
  // Clock, subclock and hang guard
  // ******************************************************
  // 20 MHz system clock
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // Subclock of ten system clocks, standing still while switched off
  initial begin
    sub_clock_in = 1'b0;
    forever begin
      repeat (5) @(posedge clock_in);
      if (sub_on) sub_clock_in <= ~sub_clock_in;
    end
  end

  // A stuck wait would otherwise run forever
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == CEILING) begin
      err_count++;
      results();
    end
  end

  // ******************************************************
  // Shared tasks
  // ******************************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // One-cycle write; the strobe drops for a cycle before the next access
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] b);
    @(posedge clock_in);
    addr_in      <= a;
    wr_data_in   <= d;
    wr_bits_in   <= b;
    wr_strobe_in <= 1'b1;
    @(posedge clock_in);
    wr_strobe_in <= 1'b0;
  endtask : wr

  // One-cycle read; the expectation goes to the queue for the monitor
  task automatic rd(input logic [15:0] a, input logic [7:0] e,
                    input string what);
    exp_q.push_back(e);
    name_q.push_back(what);
    @(posedge clock_in);
    addr_in      <= a;
    rd_strobe_in <= 1'b1;
    @(posedge clock_in);
    rd_strobe_in <= 1'b0;
  endtask : rd

  // Counts edges until the request pulse (or irq) is seen, capped
  task automatic wait_for(input bit use_irq, input int limit, output int n);
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while ((use_irq ? irq_out : tick_interrupt_request_out) !== 1'b1
               && n < limit);
  endtask : wait_for

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) check("read_unexpected", 32'h0, 32'h1);
      else check(name_q.pop_front(), {24'h0, exp_q.pop_front()},
                 {24'h0, rd_data_out});
    end
    rd_seen <= rd_strobe_in;
  end

  // ******************************************************
  // Main sequence
  // ******************************************************
  initial begin
    int n;
    int p;
    logic [7:0] d;
    rst_b_in = 1'b0;
    addr_in = 16'h0000;
    wr_data_in = 8'h00;
    wr_bits_in = 8'h00;
    wr_strobe_in = 1'b0;
    rd_strobe_in = 1'b0;
    sub_on = 1'b0;
    void'($urandom(32'h59a63677));
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    check("irq_reset", 32'h0, {31'h0, irq_out});
    rd(WATCH_MODE_OFFSET, 8'h00, "mode_reset");
    rd(EVENT_STATUS_OFFSET, 8'h00, "status_reset");
    rd(EVENT_MASK_OFFSET, 8'h00, "mask_reset");
    rd(16'hff4d, 8'h00, "unmapped_read");
    // Software keeps bits 3:2 at zero in every mode write
    wr(WATCH_MODE_OFFSET, 8'hf3, 8'hff);
    wr(16'hff4e, 8'($urandom), 8'hff);
    rd(WATCH_MODE_OFFSET, 8'hf3, "mode_byte_write");
    wr(WATCH_MODE_OFFSET, 8'h00, 8'hff);
    // Single-bit writes with random noise on unselected data bits
    d = 8'($urandom) & WATCH_MODE_WRITABLE;
    wr(WATCH_MODE_OFFSET, d | 8'h01, 8'h01);
    d = 8'($urandom) & WATCH_MODE_WRITABLE;
    wr(WATCH_MODE_OFFSET, d | 8'h02, 8'h02);
    rd(WATCH_MODE_OFFSET, 8'h03, "mode_bits_set");
    d = 8'($urandom) & WATCH_MODE_WRITABLE;
    wr(WATCH_MODE_OFFSET, d & 8'hfd, 8'h02);
    rd(WATCH_MODE_OFFSET, 8'h01, "mode_run_off");

    // Every interval code, prohibited ones too, from a cleared prescaler
    for (int c = 0; c < 8; c++) begin
      p = (16 << ((c > 5) ? 5 : c)) * DIV;
      wr(WATCH_MODE_OFFSET, 8'h00, 8'hff);
      wr(WATCH_MODE_OFFSET, {1'b0, 3'(c), 4'h1}, 8'hff);
      wait_for(1'b0, 4 * p, n);
      check("first_interval", 32'h1,
            32'(n >= p - 3 && n <= p + 6));
      wait_for(1'b0, 4 * p, n);
      check("interval_gap", 32'(p), 32'(n));
    end

    // Watch event alone on the interrupt line; first one comes late
    wr(EVENT_MASK_OFFSET, 8'h01, 8'hff);
    rd(EVENT_STATUS_OFFSET, 8'h02, "status_interval_only");
    wr(WATCH_MODE_OFFSET, 8'h00, 8'hff);
    wr(WATCH_MODE_OFFSET, 8'h53, 8'hff);
    wait_for(1'b1, 40000, n);
    p = WATCH_CLKS + 512 * DIV;
    check("first_watch", 32'h1, 32'(n >= p - 8 && n <= p + 16));
    rd(EVENT_STATUS_OFFSET, 8'h03, "status_watch");
    wait_for(1'b1, 40000, n);
    check("watch_gap", 32'(WATCH_CLKS), 32'(n + 2));
    rd(EVENT_STATUS_OFFSET, 8'h03, "status_watch_again");
    @(posedge clock_in);
    check("irq_after_read", 32'h0, {31'h0, irq_out});

    // Masked status keeps the line low until unmasked
    wr(EVENT_MASK_OFFSET, 8'h00, 8'hff);
    wait_for(1'b0, 2048, n);
    @(posedge clock_in);
    check("irq_masked", 32'h0, {31'h0, irq_out});
    wr(EVENT_MASK_OFFSET, 8'h02, 8'hff);
    @(posedge clock_in);
    check("irq_unmasked", 32'h1, {31'h0, irq_out});
    rd(EVENT_MASK_OFFSET, 8'h02, "mask_value");
    rd(EVENT_STATUS_OFFSET, 8'h02, "status_interval");
    @(posedge clock_in);
    check("irq_cleared", 32'h0, {31'h0, irq_out});

    // Dropping only the run bit leaves the interval rhythm intact
    wait_for(1'b0, 2048, n);
    d = 8'($urandom) & WATCH_MODE_WRITABLE;
    wr(WATCH_MODE_OFFSET, d & 8'hfd, 8'h02);
    wait_for(1'b0, 2048, n);
    check("gap_after_run_clear", 32'(512 * DIV), 32'(n + 2));
    rd(WATCH_MODE_OFFSET, 8'h51, "mode_after_run_clear");

    // Subclock as count clock, then no ticks once it stands still
    wr(WATCH_MODE_OFFSET, 8'h00, 8'hff);
    sub_on <= 1'b1;
    wr(WATCH_MODE_OFFSET, 8'h81, 8'hff);
    wait_for(1'b0, 1000, n);
    wait_for(1'b0, 1000, n);
    check("sub_interval_gap", 32'd160, 32'(n));
    sub_on <= 1'b0;
    wait_for(1'b0, 400, n);
    check("sub_stopped", 32'd400, 32'(n));

    // Reset in mid-run, with the unit enabled and the line high
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    check("irq_mid_reset", 32'h0, {31'h0, irq_out});
    rd(WATCH_MODE_OFFSET, 8'h00, "mode_mid_reset");
    rd(EVENT_STATUS_OFFSET, 8'h00, "status_mid_reset");
    rd(EVENT_MASK_OFFSET, 8'h00, "mask_mid_reset");
    repeat (3) @(posedge clock_in);
    results();
  end

endmodule : testbench
`default_nettype wire
